/* File: rtl/sup_pkg.sv */
// package for the supervisor timer: register layout, mode codes, intervals
// assumes one system clock and a 32 kHz clock supplied from outside
package sup_pkg;
   // register offsets (single control register plus a status word)
   localparam logic [3:0] SUP_CTRL_ADDR   = 4'h0;
   localparam logic [3:0] SUP_STAT_ADDR   = 4'h1;
   // control field positions
   localparam int SUP_KICK_MSB  = 7;
   localparam int SUP_KICK_LSB  = 4;
   localparam int SUP_MODE_MSB  = 3;
   localparam int SUP_MODE_LSB  = 2;
   localparam int SUP_INTV_MSB  = 1;
   localparam int SUP_INTV_LSB  = 0;
   // mode codes
   localparam logic [1:0] SUP_MODE_IDLE0 = 2'h0;
   localparam logic [1:0] SUP_MODE_IDLE1 = 2'h1;
   localparam logic [1:0] SUP_MODE_WDOG  = 2'h2;
   localparam logic [1:0] SUP_MODE_TIMER = 2'h3;
   // kick codes
   localparam logic [3:0] SUP_KICK_FIRST  = 4'ha;
   localparam logic [3:0] SUP_KICK_SECOND = 4'h5;
   // counter width and terminal counts
   localparam int          SUP_CNT_W    = 15;
   localparam logic [15:0] SUP_TERM_00  = 16'h8000;
   localparam logic [15:0] SUP_TERM_01  = 16'h2000;
   localparam logic [15:0] SUP_TERM_10  = 16'h0200;
   localparam logic [15:0] SUP_TERM_11  = 16'h0040;
   localparam logic [1:0]  SUP_INTV_RST = 2'h0;
   localparam logic [7:0]  SUP_ZERO8    = 8'h00;

   typedef enum logic [1:0] {
      SUP_IDLE,
      SUP_WATCH,
      SUP_TIMING
   } sup_state_t;

   // register bus request carried as one bundle
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } sup_req_t;
endpackage : sup_pkg

/* File: rtl/sup_sync.sv */
// two-stage synchroniser for a level from another clock domain
// assumes the level is slow against sys_clk_in
`timescale 1ns/1ps
`default_nettype none
module sup_sync (
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic sys_rst_in,
   input  wire logic clk_en_in,
   // data
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_reg;
   logic sync_reg;
   // first stage is read only by the second
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else if (clk_en_in) begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end
   assign sync_out = sync_reg;
endmodule : sup_sync
`default_nettype wire

/* File: rtl/sup_tick.sv */
// edge detector turning the synchronised 32 kHz level into a one-cycle tick
// assumes its input is already synchronised to sys_clk_in
`timescale 1ns/1ps
`default_nettype none
module sup_tick (
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic sys_rst_in,
   input  wire logic clk_en_in,
   // data
   input  wire logic level_in,
   output logic      tick_out
);
   logic last_reg;
   // rising edge of the slow clock marks one counting period
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         last_reg <= 1'b0;
      end else if (clk_en_in) begin
         last_reg <= level_in;
      end
   end
   assign tick_out = level_in & ~last_reg & clk_en_in;
endmodule : sup_tick
`default_nettype wire

/* File: rtl/sup_timer.sv */
// supervisor timer: watchdog or interval timer on a 15-bit up-counter
// assumes slow_clk_in is a free 32 kHz clock from another domain and that
// power modes gate clk_en_in rather than asserting reset
//
// Function
// RL1: 15-bit up-counter on 32 kHz clock, hidden from software, off after reset.
// RL2: counter value kept through low-power modes, counting resumes from it.
// RL3: mode 10 written while idle starts watchdog counting from zero.
// RL4: in watchdog mode, mode writes 00 or 01 are ignored.
// RL5: in watchdog mode the interval field is frozen.
// RL6: interval 00/01/10/11 selects 32768/8192/512/64 periods.
// RL7: watchdog reaching interval without a clear requests system reset.
// RL8: kick 0xA then 0x5 within one period clears counter, counting goes on.
// RL9: missing 0x5 in time discards the partial kick, needs fresh 0xA.
// RL10: watchdog mode never raises an interrupt.
// RL11: mode 11 written while idle starts timer mode from zero.
// RL12: timer reaching interval sets the interrupt flag, no reset.
// RL13: timer mode: kick bit 0 set zeroes counter, upper bits ignored.
// RL14: timer mode: mode 00 or 01 stops and zeroes the counter.
// RL15: interval accepted only while idle, so write it with the start.
// RL16: once watchdog entered, timer mode refused until chip reset.
// RL17: kick writes while idle do nothing; kick field reads zero.
// RL18: software goes timer to watchdog via an idle write first.
`timescale 1ns/1ps
`default_nettype none
module sup_timer
   import sup_pkg::*;
#(
   parameter int CNT_W = SUP_CNT_W
) (
   // clock, reset, enable
   input  wire logic              sys_clk_in,
   input  wire logic              sys_rst_in,
   input  wire logic              clk_en_in,
   // slow counting clock from another domain
   input  wire logic              slow_clk_in,
   // register port
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   input  wire logic [3:0]        reg_addr_in,
   input  wire logic [7:0]        reg_wdata_in,
   output logic      [7:0]        reg_rdata_out,
   // interrupt flag acknowledge from the interrupt controller
   input  wire logic              irq_flag_clr_in,
   // outputs
   output logic                   timer_expiry_irq_flag_out,
   output logic                   sys_reset_req_out
);
   import sup_pkg::*;

   // whole state of the block
   typedef struct packed {
      sup_state_t       state;
      logic [CNT_W-1:0] cnt;
      logic [1:0]       intv;
      logic             kick_armed;
      logic             armed_tick;
      logic             irq_flag;
      logic             rst_req;
      logic [7:0]       rdata;
   } sup_all_t;

   sup_all_t all_reg;
   sup_all_t all_next;
   sup_req_t req;
   logic     slow_sync;
   logic     tick;

   // terminal count for an interval code, shared by both modes
   function automatic logic [15:0] sup_term(input logic [1:0] code);
      logic [15:0] t;
      t = SUP_TERM_00;
      case (code)
         2'h0: t = SUP_TERM_00;                           // RL6
         2'h1: t = SUP_TERM_01;
         2'h2: t = SUP_TERM_10;
         default: t = SUP_TERM_11;
      endcase
      return t;
   endfunction : sup_term

   assign req.wr    = reg_wr_in;
   assign req.rd    = reg_rd_in;
   assign req.addr  = reg_addr_in;
   assign req.wdata = reg_wdata_in;

   // slow clock crosses into the system domain as a level
   sup_sync u_sync (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .clk_en_in  (clk_en_in),
      .async_in   (slow_clk_in),
      .sync_out   (slow_sync)
   );

   // one tick per slow clock period
   sup_tick u_tick (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .clk_en_in  (clk_en_in),
      .level_in   (slow_sync),
      .tick_out   (tick)
   );

   // next-state logic
   always_comb begin
      logic             ctrl_wr;
      logic [1:0]       wmode;
      logic [3:0]       wkick;
      logic [CNT_W:0]   cnt_inc;
      logic             at_term;
      ctrl_wr  = req.wr && (req.addr == SUP_CTRL_ADDR);
      wmode    = req.wdata[SUP_MODE_MSB:SUP_MODE_LSB];
      wkick    = req.wdata[SUP_KICK_MSB:SUP_KICK_LSB];
      cnt_inc  = {1'b0, all_reg.cnt} + 1'b1;
      // sized to the terminal-count width; no zero-width replication
      at_term  = (16'(cnt_inc) == sup_term(all_reg.intv));
      all_next = all_reg;
      all_next.rdata = SUP_ZERO8;

      // counting on each slow tick; power modes freeze via clk_en_in
      if (tick && all_reg.state != SUP_IDLE) begin        // RL1 RL2
         all_next.cnt = cnt_inc[CNT_W-1:0];
         if (at_term) begin
            all_next.cnt = '0;
            if (all_reg.state == SUP_WATCH) begin
               all_next.rst_req = 1'b1;                   // RL7 RL10
            end else begin
               all_next.irq_flag = 1'b1;                  // RL12
            end
         end
      end

      // partial kick expires after one full slow period
      if (tick && all_reg.kick_armed) begin
         if (all_reg.armed_tick) begin
            all_next.kick_armed = 1'b0;                   // RL9
         end else begin
            all_next.armed_tick = 1'b1;
         end
      end

      // software clears the flag; a new expiry in the same cycle wins
      if (irq_flag_clr_in && !(tick && at_term
                               && all_reg.state == SUP_TIMING)) begin
         all_next.irq_flag = 1'b0;
      end

      // control register writes
      if (ctrl_wr) begin
         case (all_reg.state)
            SUP_IDLE: begin                               // RL17
               all_next.intv = req.wdata[SUP_INTV_MSB:SUP_INTV_LSB]; // RL15
               if (wmode == SUP_MODE_WDOG) begin
                  all_next.state = SUP_WATCH;             // RL3
                  all_next.cnt   = '0;
               end else if (wmode == SUP_MODE_TIMER) begin
                  all_next.state = SUP_TIMING;            // RL11
                  all_next.cnt   = '0;
               end
            end
            SUP_WATCH: begin
               // mode and interval frozen; no way back    RL4 RL5 RL16
               if (wkick == SUP_KICK_FIRST) begin
                  all_next.kick_armed = 1'b1;
                  all_next.armed_tick = 1'b0;
               end else if (wkick == SUP_KICK_SECOND
                            && all_reg.kick_armed) begin
                  all_next.cnt        = '0;               // RL8
                  all_next.kick_armed = 1'b0;
                  all_next.rst_req    = 1'b0;
               end else begin
                  all_next.kick_armed = 1'b0;             // RL9
               end
            end
            default: begin
               if (wmode == SUP_MODE_IDLE0 || wmode == SUP_MODE_IDLE1) begin
                  all_next.state = SUP_IDLE;              // RL14 RL18
                  all_next.cnt   = '0;
               end else if (wkick[0]) begin
                  all_next.cnt   = '0;                    // RL13
               end
            end
         endcase
      end

      // read: kick field always zero
      if (req.rd) begin
         if (req.addr == SUP_CTRL_ADDR) begin
            all_next.rdata = {4'h0,                       // RL17
               (all_reg.state == SUP_WATCH)  ? SUP_MODE_WDOG :
               (all_reg.state == SUP_TIMING) ? SUP_MODE_TIMER :
                                               SUP_MODE_IDLE0,
               all_reg.intv};
         end else if (req.addr == SUP_STAT_ADDR) begin
            all_next.rdata = {6'h00, all_reg.rst_req, all_reg.irq_flag};
         end else begin
            all_next.rdata = SUP_ZERO8;
         end
      end
   end

   // state register; reset leaves the unit idle
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         all_reg.state      <= SUP_IDLE;                  // RL1
         all_reg.cnt        <= '0;
         all_reg.intv       <= SUP_INTV_RST;
         all_reg.kick_armed <= 1'b0;
         all_reg.armed_tick <= 1'b0;
         all_reg.irq_flag   <= 1'b0;
         all_reg.rst_req    <= 1'b0;
         all_reg.rdata      <= SUP_ZERO8;
      end else if (clk_en_in) begin
         all_reg <= all_next;
      end
   end

   assign reg_rdata_out             = all_reg.rdata;
   assign timer_expiry_irq_flag_out = all_reg.irq_flag;
   assign sys_reset_req_out         = all_reg.rst_req;
endmodule : sup_timer
`default_nettype wire

/* File: tb/sup_timer_properties.sv */
// port checker for the supervisor timer, bound into sup_timer
// assumes one clock domain and the register timing of the design
`timescale 1ns/1ps
`default_nettype none
module sup_props
   import sup_pkg::*;
#(
   parameter int CNT_W = SUP_CNT_W
) (
   // clock and reset
   input wire logic       sys_clk_in,
   input wire logic       sys_rst_in,
   input wire logic       clk_en_in,
   // register port
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   // flags
   input wire logic       timer_expiry_irq_flag_out,
   input wire logic       sys_reset_req_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   logic [1:0] mode_reg;
   logic [1:0] mode_next;
   logic       ctl_wr;
   logic       rd_ctl;
   logic [1:0] wmd;
   // decoded control accesses
   assign wmd = reg_wdata_in[SUP_MODE_MSB:SUP_MODE_LSB];
   assign ctl_wr = reg_wr_in && clk_en_in && reg_addr_in == SUP_CTRL_ADDR;
   assign rd_ctl = reg_rd_in && clk_en_in && reg_addr_in == SUP_CTRL_ADDR;
   // own mode tracker, so a stuck design state cannot hide itself
   always_comb begin
      mode_next = mode_reg;
      if (ctl_wr && mode_reg == SUP_MODE_IDLE0 && wmd[1]) begin
         mode_next = wmd;
      end else if (ctl_wr && mode_reg == SUP_MODE_TIMER && !wmd[1]) begin
         mode_next = SUP_MODE_IDLE0;
      end
   end
   // tracker register
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mode_reg <= SUP_MODE_IDLE0;
      end else begin
         mode_reg <= mode_next;
      end
   end
   property p_kick_rd; $past(rd_ctl) |-> reg_rdata_out[7:4] == 4'h0;
   endproperty
   a_kick_rd: assert property (p_kick_rd)
      else $error("kick field read back nonzero");
   property p_wd_hold; $past(rd_ctl && mode_reg == SUP_MODE_WDOG)
      |-> reg_rdata_out[3:2] == SUP_MODE_WDOG; endproperty
   a_wd_hold: assert property (p_wd_hold)
      else $error("watchdog mode left");
   property p_no_irq_wd; mode_reg == SUP_MODE_WDOG
      |-> !$rose(timer_expiry_irq_flag_out); endproperty
   a_no_irq_wd: assert property (p_no_irq_wd)
      else $error("interrupt raised in watchdog mode");
   property p_no_rst_tm; mode_reg != SUP_MODE_WDOG
      |-> !$rose(sys_reset_req_out); endproperty
   a_no_rst_tm: assert property (p_no_rst_tm)
      else $error("reset request outside watchdog mode");
   property p_rst_hold; sys_reset_req_out && !reg_wr_in
      |=> sys_reset_req_out; endproperty
   a_rst_hold: assert property (p_rst_hold)
      else $error("reset request dropped");
   property p_frozen; !clk_en_in |=> $stable(sys_reset_req_out)
      && $stable(timer_expiry_irq_flag_out); endproperty
   a_frozen: assert property (p_frozen)
      else $error("flags moved while frozen");
   property p_start; ctl_wr && mode_reg == SUP_MODE_IDLE0 && wmd[1]
      |=> (!$rose(timer_expiry_irq_flag_out))[*8]; endproperty
   a_start: assert property (p_start)
      else $error("expiry right after start");
   property p_stat; $past(reg_rd_in && clk_en_in
      && reg_addr_in == SUP_STAT_ADDR)
      |-> reg_rdata_out[1:0] == $past({sys_reset_req_out,
      timer_expiry_irq_flag_out}); endproperty
   a_stat: assert property (p_stat)
      else $error("status read mismatch");
endmodule : sup_props
bind sup_timer sup_props #(.CNT_W(CNT_W)) u_props (
   .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .timer_expiry_irq_flag_out(timer_expiry_irq_flag_out),
   .sys_reset_req_out(sys_reset_req_out));
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the supervisor timer with an integer model
// assumes the bench drives all ports itself and makes the slow clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sup_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        en = 1'b1;
   logic        slow = 1'b0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        clr = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata;
   logic        irq;
   logic        rreq;
   logic [31:0] seed = 32'h00009c03; // xorshift start value
   logic [31:0] r;
   int          mismatches = 0;
   int          check_count = 0;
   int          terms[4] = '{32768, 8192, 512, 64};
   int          m_cnt, m_mode, m_term, m_age;
   bit          m_irq, m_rst;
   always #5 clk = ~clk;
   sup_timer dut (.sys_clk_in(clk), .sys_rst_in(rst), .clk_en_in(en),
      .slow_clk_in(slow), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .irq_flag_clr_in(clr), .timer_expiry_irq_flag_out(irq),
      .sys_reset_req_out(rreq));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic chk_flags();
      check("irq flag", {7'h00, m_irq}, {7'h00, irq});
      check("reset request", {7'h00, m_rst}, {7'h00, rreq});
   endtask : chk_flags
   // chip reset, model cleared alongside
   task automatic chip_reset();
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      {m_cnt, m_mode, m_irq, m_rst, m_age} = {32'd0, 32'd0, 2'b00, 32'd9};
   endtask : chip_reset
   // bus write; the model takes it as the design should
   task automatic wr_reg(logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      if (a == SUP_CTRL_ADDR) begin
         if (m_mode == 0 && d[3]) begin
            {m_mode, m_cnt, m_term} = {30'd0, d[3:2], 32'd0, terms[d[1:0]]};
         end else if (m_mode == 3 && !d[3]) begin
            {m_mode, m_cnt} = 64'd0;
         end else if (m_mode == 3 && d[4]) begin
            m_cnt = 0;
         end else if (m_mode == 2 && d[7:4] == SUP_KICK_FIRST) begin
            m_age = 0;
         end else if (m_mode == 2) begin
            if (d[7:4] == SUP_KICK_SECOND && m_age < 2) begin
               {m_cnt, m_rst} = 33'd0;
            end
            m_age = 9;
         end
      end
   endtask : wr_reg
   // bus read, data compared in the one cycle it stands
   task automatic rd_chk(logic [3:0] a, logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 check("read data", e, rdata);
      // realign to an edge so whatever follows drives on the clock
      @(posedge clk);
   endtask : rd_chk
   // slow clock pulses only on demand, so expiry moments are exact
   task automatic ticks(int n);
      repeat (n) begin
         slow <= 1'b1;
         repeat (4) @(posedge clk);
         slow <= 1'b0;
         repeat (4) @(posedge clk);
         m_age++;
         if (m_mode != 0 && ++m_cnt == m_term) begin
            m_cnt = 0;
            if (m_mode == 3) m_irq = 1'b1;
            else m_rst = 1'b1;
         end
      end
   endtask : ticks
   task automatic irq_clr();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      m_irq = 1'b0;
      @(posedge clk);
   endtask : irq_clr
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict
   // hang guard, above the expected 72k cycles but inside the run budget
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      print_verdict();
   end
   initial begin
      chip_reset();
      rd_chk(SUP_CTRL_ADDR, 8'h00);
      wr_reg(SUP_CTRL_ADDR, 8'ha0);
      rd_chk(4'h7, 8'h00);
      ticks(3);
      chk_flags();
      $display("test reset done");
      wr_reg(SUP_CTRL_ADDR, 8'h0f);
      rd_chk(SUP_CTRL_ADDR, 8'h0f);
      ticks(40);
      en <= 1'b0;
      repeat (20) @(posedge clk);
      en <= 1'b1;
      ticks(23);
      chk_flags();
      ticks(1);
      chk_flags();
      irq_clr();
      ticks(20);
      r = rnd();
      wr_reg(SUP_CTRL_ADDR, {r[7:5], 3'b111, r[1:0]});
      ticks(63);
      chk_flags();
      ticks(1);
      chk_flags();
      wr_reg(SUP_CTRL_ADDR, 8'h00);
      irq_clr();
      ticks(70);
      chk_flags();
      for (int i = 1; i <= 2; i++) begin
         wr_reg(SUP_CTRL_ADDR, 8'h0c | 8'(i));
         ticks(terms[i] - 1);
         chk_flags();
         ticks(1);
         chk_flags();
         wr_reg(SUP_CTRL_ADDR, 8'h04);
         irq_clr();
      end
      $display("test timer done");
      wr_reg(SUP_CTRL_ADDR, 8'h0b);
      ticks(30);
      r = rnd();
      wr_reg(SUP_CTRL_ADDR, 8'h00);
      wr_reg(SUP_CTRL_ADDR, {6'h03, r[1:0]});
      rd_chk(SUP_CTRL_ADDR, 8'h0b);
      wr_reg(SUP_CTRL_ADDR, 8'ha0);
      wr_reg(SUP_CTRL_ADDR, 8'h50);
      ticks(10);
      wr_reg(SUP_CTRL_ADDR, 8'ha0);
      ticks(2);
      wr_reg(SUP_CTRL_ADDR, 8'h50);
      ticks(51);
      chk_flags();
      ticks(1);
      chk_flags();
      wr_reg(SUP_CTRL_ADDR, 8'ha0);
      wr_reg(SUP_CTRL_ADDR, 8'h50);
      rd_chk(SUP_STAT_ADDR, 8'h00);
      $display("test watchdog done");
      chip_reset();
      wr_reg(SUP_CTRL_ADDR, 8'h0f);
      rd_chk(SUP_CTRL_ADDR, 8'h0f);
      $display("test rereset done");
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
